// [verilog/sebs_top.sv]
`timescale 1ns/1ps
module sebs_top #(
  parameter int HIGH_BITS = sebs_pkg::HIGH_BITS_DEFAULT,
  parameter int WRITE_CYCLES = sebs_pkg::WRITE_CYCLES,
  parameter int FIFO_DEPTH = sebs_pkg::FIFO_DEPTH_DEFAULT,
  parameter logic [3:0] DEVICE_TYPE = sebs_pkg::DEVICE_TYPE_DEFAULT
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic CHIP_SELECT_PIN_LOW,
  input wire logic CHIP_SELECT_PIN_MID,
  input wire logic CHIP_SELECT_PIN_HIGH,
  input wire logic WRITE_INHIBIT_PIN,
  output logic BUSY
);
  localparam int ADDR_W = sebs_pkg::BYTE_BITS + HIGH_BITS;
  localparam int MEM_BYTES = 1 << ADDR_W;
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [CW-1:0] FIFO_FULL = CW'(FIFO_DEPTH);
  localparam logic [31:0] WC_LAST = 32'(WRITE_CYCLES - 1);

  function automatic logic sel_match(input logic [7:0] sel,
                                     input logic [2:0] cs);
    logic ok;
    ok = (sel[7:sebs_pkg::TYPE_LSB] == DEVICE_TYPE);
    for (int i = 0; i < sebs_pkg::CS_BITS; i++) begin
      // Positions taken by address bits skip the pin compare
      if (i >= HIGH_BITS &&
          sel[sebs_pkg::CS_LSB + i] != cs[i]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  function automatic logic [ADDR_W-1:0] join_addr(
      input logic [7:0] sel, input logic [7:0] low);
    logic [10:0] full;
    full = {sel[3:1], low};
    return full[ADDR_W-1:0];
  endfunction

  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    return (p == PW'(FIFO_DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  sebs_pkg::sebs_pins_t pin_a;
  sebs_pkg::sebs_pins_t pin_b;
  sebs_pkg::sebs_pins_t pin_c;
  sebs_pkg::sebs_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shift_in;
  logic [7:0] out_shift;
  logic [7:0] sel_byte;
  logic rw;
  logic mack;
  logic ack_done;
  logic wi_seen;
  logic [ADDR_W-1:0] addr;
  logic [7:0] page_data [sebs_pkg::PAGE_BYTES];
  logic [sebs_pkg::PAGE_BYTES-1:0] page_valid;
  logic [ADDR_W-sebs_pkg::PAGE_BITS-1:0] page_row;
  logic [7:0] mem [MEM_BYTES];
  logic [31:0] wc_count;
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] fifo_count;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic reading;
  logic fill_valid;
  logic fill_ready;
  logic drain_valid;
  logic drain_ready;
  logic [7:0] drain_data;
  logic [ADDR_W-1:0] fetch_addr;
  logic page_store;
  logic page_clear;
  logic trigger;

  // Three flops on every pin; only pin_b and pin_c feed logic
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pin_a <= '1;
      pin_b <= '1;
      pin_c <= '1;
    end else if (CE) begin
      pin_a <= {SCL, SDA_IN, CHIP_SELECT_PIN_HIGH, CHIP_SELECT_PIN_MID,
                CHIP_SELECT_PIN_LOW, WRITE_INHIBIT_PIN};
      pin_b <= pin_a;
      pin_c <= pin_b;
    end
  end

  assign scl_rise = ~pin_c.scl & pin_b.scl;
  assign scl_fall = pin_c.scl & ~pin_b.scl;
  // Data line disabled while the write cycle runs
  assign start_ev = pin_c.scl & pin_b.scl & pin_c.sda & ~pin_b.sda
                    & ~BUSY;
  assign stop_ev = pin_c.scl & pin_b.scl & ~pin_c.sda & pin_b.sda
                   & ~BUSY;

  assign reading = rw && (state == sebs_pkg::ST_DEV_ACK ||
                          state == sebs_pkg::ST_RDATA ||
                          state == sebs_pkg::ST_RDATA_ACK);
  assign fill_valid = reading;
  assign fill_ready = (fifo_count != FIFO_FULL);
  assign drain_valid = (fifo_count != '0);
  assign drain_data = fifo_mem[rd_ptr];
  // Prefetch runs ahead of the counter by the entries held
  assign fetch_addr = ADDR_W'(addr + ADDR_W'(fifo_count));
  assign drain_ready = scl_fall && !start_ev && !stop_ev &&
                       ((state == sebs_pkg::ST_DEV_ACK && rw) ||
                        (state == sebs_pkg::ST_RDATA_ACK && mack));
  assign page_store = scl_fall && !start_ev && !stop_ev && !wi_seen &&
                      state == sebs_pkg::ST_WDATA &&
                      bitcnt == sebs_pkg::BITCNT_FULL;
  assign page_clear = scl_fall && state == sebs_pkg::ST_ADDR &&
                      bitcnt == sebs_pkg::BITCNT_FULL;
  // Stop counts only in the slot right after an acked data byte
  // Its own clock rise has already shifted in that one bit
  assign trigger = stop_ev && state == sebs_pkg::ST_WDATA &&
                   bitcnt == 4'h1 && ack_done;

  assign SDA_OUT = 1'b0;

  // Inhibit level is caught from start through the address byte
  always_ff @(posedge CLK) begin
    if (RESET) begin
      wi_seen <= 1'b0;
    end else if (CE) begin
      if (start_ev) begin
        wi_seen <= pin_b.wi;
      end else if (state == sebs_pkg::ST_DEV ||
                   state == sebs_pkg::ST_DEV_ACK ||
                   state == sebs_pkg::ST_ADDR) begin
        wi_seen <= wi_seen | pin_b.wi;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= sebs_pkg::ST_IDLE;
      bitcnt <= '0;
      shift_in <= '0;
      out_shift <= '0;
      sel_byte <= '0;
      rw <= 1'b0;
      mack <= 1'b0;
      ack_done <= 1'b0;
      addr <= '0;
      SDA_OE <= 1'b0;
    end else if (CE) begin
      if (start_ev) begin
        state <= sebs_pkg::ST_DEV;
        bitcnt <= '0;
        rw <= 1'b0;
        SDA_OE <= 1'b0;
      end else if (stop_ev) begin
        state <= sebs_pkg::ST_IDLE;
        SDA_OE <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          sebs_pkg::ST_DEV, sebs_pkg::ST_ADDR, sebs_pkg::ST_WDATA: begin
            shift_in <= {shift_in[6:0], pin_b.sda};
            bitcnt <= 4'(bitcnt + 1'b1);
          end
          sebs_pkg::ST_RDATA: begin
            bitcnt <= 4'(bitcnt + 1'b1);
          end
          sebs_pkg::ST_RDATA_ACK: begin
            mack <= ~pin_b.sda;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state)
          sebs_pkg::ST_DEV: begin
            if (bitcnt == sebs_pkg::BITCNT_FULL) begin
              if (sel_match(shift_in, pin_b.cs)) begin
                sel_byte <= shift_in;
                rw <= shift_in[sebs_pkg::RW_POS];
                addr <= join_addr(shift_in, addr[7:0]);
                state <= sebs_pkg::ST_DEV_ACK;
                SDA_OE <= 1'b1;
              end else begin
                state <= sebs_pkg::ST_IDLE;
              end
            end
          end
          sebs_pkg::ST_DEV_ACK: begin
            bitcnt <= '0;
            if (rw) begin
              // First byte out at the current counter
              out_shift <= drain_data;
              SDA_OE <= ~drain_data[7];
              addr <= ADDR_W'(addr + 1'b1);
              state <= sebs_pkg::ST_RDATA;
            end else begin
              SDA_OE <= 1'b0;
              state <= sebs_pkg::ST_ADDR;
            end
          end
          sebs_pkg::ST_ADDR: begin
            if (bitcnt == sebs_pkg::BITCNT_FULL) begin
              addr <= join_addr(sel_byte, shift_in);
              ack_done <= 1'b0;
              state <= sebs_pkg::ST_ADDR_ACK;
              SDA_OE <= 1'b1;
            end
          end
          sebs_pkg::ST_ADDR_ACK: begin
            SDA_OE <= 1'b0;
            bitcnt <= '0;
            state <= sebs_pkg::ST_WDATA;
          end
          sebs_pkg::ST_WDATA: begin
            if (bitcnt == sebs_pkg::BITCNT_FULL) begin
              SDA_OE <= ~wi_seen;
              addr[3:0] <= 4'(addr[3:0] + 1'b1);
              state <= sebs_pkg::ST_WDATA_ACK;
            end
          end
          sebs_pkg::ST_WDATA_ACK: begin
            SDA_OE <= 1'b0;
            ack_done <= ~wi_seen;
            bitcnt <= '0;
            state <= sebs_pkg::ST_WDATA;
          end
          sebs_pkg::ST_RDATA: begin
            if (bitcnt == sebs_pkg::BITCNT_FULL) begin
              SDA_OE <= 1'b0;
              mack <= 1'b0;
              state <= sebs_pkg::ST_RDATA_ACK;
            end else begin
              out_shift <= {out_shift[6:0], 1'b0};
              SDA_OE <= ~out_shift[6];
            end
          end
          sebs_pkg::ST_RDATA_ACK: begin
            bitcnt <= '0;
            if (mack) begin
              out_shift <= drain_data;
              SDA_OE <= ~drain_data[7];
              addr <= ADDR_W'(addr + 1'b1);
              state <= sebs_pkg::ST_RDATA;
            end else begin
              state <= sebs_pkg::ST_IDLE;
            end
          end
          default: begin
            SDA_OE <= 1'b0;
          end
        endcase
      end
    end
  end

  // Page latch gathers the row; excess bytes overwrite in place
  always_ff @(posedge CLK) begin
    if (RESET) begin
      page_valid <= '0;
      page_row <= '0;
      for (int i = 0; i < sebs_pkg::PAGE_BYTES; i++) begin
        page_data[i] <= '0;
      end
    end else if (CE) begin
      if (page_clear) begin
        page_valid <= '0;
      end else if (page_store) begin
        page_data[addr[3:0]] <= shift_in;
        page_valid[addr[3:0]] <= 1'b1;
        page_row <= addr[ADDR_W-1:sebs_pkg::PAGE_BITS];
      end
    end
  end

  // Memory updates in one step when the timed cycle ends
  always_ff @(posedge CLK) begin
    if (RESET) begin
      BUSY <= 1'b0;
      wc_count <= '0;
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem[i] <= sebs_pkg::MEM_RESET;
      end
    end else if (CE) begin
      if (trigger) begin
        BUSY <= 1'b1;
        wc_count <= WC_LAST;
      end else if (BUSY) begin
        if (wc_count == '0) begin
          BUSY <= 1'b0;
          for (int i = 0; i < sebs_pkg::PAGE_BYTES; i++) begin
            if (page_valid[i]) begin
              mem[{page_row, 4'(i)}] <= page_data[i];
            end
          end
        end else begin
          wc_count <= 32'(wc_count - 1'b1);
        end
      end
    end
  end

  // FIFO_DEPTH-entry prefetch, two by default; fill stalls while full, so no byte is lost
  always_ff @(posedge CLK) begin
    if (RESET) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_count <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_mem[i] <= '0;
      end
    end else if (CE) begin
      if (!reading) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        fifo_count <= '0;
      end else begin
        if (fill_valid && fill_ready) begin
          fifo_mem[wr_ptr] <= mem[fetch_addr];
          wr_ptr <= ptr_next(wr_ptr);
        end
        if (drain_valid && drain_ready) begin
          rd_ptr <= ptr_next(rd_ptr);
        end
        if ((fill_valid && fill_ready) &&
            !(drain_valid && drain_ready)) begin
          fifo_count <= CW'(fifo_count + 1'b1);
        end else if (!(fill_valid && fill_ready) &&
                     (drain_valid && drain_ready)) begin
          fifo_count <= CW'(fifo_count - 1'b1);
        end
      end
    end
  end
endmodule

// [verilog/sebs_pkg.sv]
package sebs_pkg;
  localparam int CLK_KHZ = 40000;
  localparam int WRITE_TIME_US = 5000;
  // Longest time, so the division rounds down
  localparam int WRITE_CYCLES = WRITE_TIME_US * (CLK_KHZ / 1000);
  localparam int BYTE_BITS = 8;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_BITS = 4;
  localparam int RW_POS = 0;
  localparam int CS_LSB = 1;
  localparam int CS_BITS = 3;
  localparam int TYPE_LSB = 4;
  localparam int HIGH_BITS_DEFAULT = 0;
  localparam int FIFO_DEPTH_DEFAULT = 2;
  // Arbitrary value for the device type identifier
  localparam logic [3:0] DEVICE_TYPE_DEFAULT = 4'h5;
  localparam logic [7:0] MEM_RESET = 8'hff;
  localparam logic [3:0] BITCNT_FULL = 4'h8;

  typedef struct packed {
    logic scl;
    logic sda;
    logic [2:0] cs;
    logic wi;
  } sebs_pins_t;

  typedef enum {
    ST_IDLE,
    ST_DEV,
    ST_DEV_ACK,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } sebs_state_t;
endpackage

// [dv/sebs_top_checker.sv]
`timescale 1ns/1ps
module sebs_top_checker #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic SCL,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  int busy_cnt;
  // Busy period is too long for a repetition
  always_ff @(posedge CLK) begin
    if (RESET || !BUSY) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end
  sequence s_stop;
    SCL && $past(SCL) && $rose(SDA_IN);
  endsequence
  sequence s_quiet;
    !SDA_OE [*4];
  endsequence
  property p_open_drain; SDA_OUT == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data value not low");
  property p_oe_stands; SCL && $past(SCL) |-> $stable(SDA_OE); endproperty
  a_oe_stands: assert property (p_oe_stands)
    else $error("data changed while clock high");
  property p_ack_release; $rose(SDA_OE) |-> ##[1:90] !SDA_OE; endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("data line held too long");
  property p_stop_quiet; s_stop |-> s_quiet; endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("driving after stop");
  property p_write_trig;
    $rose(BUSY) |-> SCL && SDA_IN && !$past(SDA_IN, 6);
  endproperty
  a_write_trig: assert property (p_write_trig)
    else $error("write cycle without stop");
  property p_busy_quiet; BUSY |-> !SDA_OE; endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("answer during write cycle");
  property p_busy_hold; $rose(BUSY) |-> BUSY [*8]; endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("write cycle too short");
  property p_busy_len; $fell(BUSY) |-> busy_cnt == WRITE_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("write cycle length wrong");
endmodule
bind sebs_top sebs_top_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .CLK(CLK), .RESET(RESET), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .BUSY(BUSY));

// [dv/sebs_master.sv]
`timescale 1ns/1ps
module sebs_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Quarter of the 200 ns link period
  task automatic q();
    repeat (2) @(posedge clk);
  endtask
  // Works as repeated start from clock low too
  task automatic start();
    sda_low <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
  endtask
  // Nine cells, first bit first; a one releases the line
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_low <= ~tx[i];
      q();
      scl <= 1'b1;
      q();
      rx[i] = sda;
      q();
      scl <= 1'b0;
      q();
    end
  endtask
endmodule

// [dv/tb_sebs_top.sv]
`timescale 1ns/1ps
module tb_sebs_top;
  localparam int WC = 150;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wi = 1'b0;
  logic [2:0] pins = 3'h0;
  logic sda_oe, busy, scl, sda_low, inh;
  logic timed_out = 1'b0;
  logic [7:0] mem [512];
  logic [8:0] ctr;
  int n_mismatch = 0;
  int n_checks = 0;
  // Pull-up wins unless someone pulls low
  wire logic sda = ~(sda_low | sda_oe);
  sebs_top #(.HIGH_BITS(1), .WRITE_CYCLES(WC)) u_sebs_top (
    .CLK(clk), .RESET(reset), .CE(1'b1), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(), .SDA_OE(sda_oe), .CHIP_SELECT_PIN_LOW(pins[0]),
    .CHIP_SELECT_PIN_MID(pins[1]), .CHIP_SELECT_PIN_HIGH(pins[2]),
    .WRITE_INHIBIT_PIN(wi), .BUSY(busy));
  sebs_master u_sebs_master (.clk(clk), .sda(sda), .scl(scl),
    .sda_low(sda_low));
  initial forever #12.5 clk = ~clk;
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %0t: byte %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_ack(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %0t: flag %b not %b", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] sel(input logic hi, input logic rw);
    return {sebs_pkg::DEVICE_TYPE_DEFAULT, pins[2], pins[1], hi, rw};
  endfunction
  task automatic put(input logic [7:0] b, input logic exp);
    logic [8:0] rx;
    u_sebs_master.xfer({b, 1'b1}, rx);
    chk_ack(~rx[0], exp);
  endtask
  task automatic get(input logic mack, input logic [7:0] exp);
    logic [8:0] rx;
    u_sebs_master.xfer({8'hff, ~mack}, rx);
    chk_byte(rx[8:1], exp);
  endtask
  task automatic wr(input logic [8:0] a, input int n);
    logic [7:0] d;
    inh = wi;
    u_sebs_master.start();
    put(sel(a[8], 1'b0), 1'b1);
    put(a[7:0], 1'b1);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      put(d, !inh);
      if (!inh) mem[{a[8:4], 4'(a[3:0] + i[3:0])}] = d;
    end
    if (!inh) ctr = {a[8:4], 4'(a[3:0] + n[3:0])};
    u_sebs_master.stop();
    repeat (6) @(posedge clk);
    chk_ack(busy, n > 0 && !inh);
  endtask
  // Busy device ignores the first polls
  task automatic poll();
    logic [8:0] rx;
    int k;
    k = 0;
    do begin
      u_sebs_master.start();
      u_sebs_master.xfer({sel(1'b0, 1'b0), 1'b1}, rx);
      k++;
    end while (rx[0] !== 1'b0 && k < 6);
    chk_ack(k > 1 && k < 6, 1'b1);
    timed_out = (k == 6);
    u_sebs_master.stop();
  endtask
  task automatic rd(input logic [8:0] a, input int m, input logic dummy);
    if (dummy) begin
      u_sebs_master.start();
      put(sel(a[8], 1'b0), 1'b1);
      put(a[7:0], 1'b1);
      ctr = a;
    end
    u_sebs_master.start();
    put(sel(ctr[8], 1'b1), 1'b1);
    for (int i = 0; i < m; i++) begin
      get(i < m - 1, mem[ctr]);
      ctr = ctr + 9'h1;
    end
    u_sebs_master.stop();
  endtask
  initial begin
    void'($urandom(32'h91cc));
    for (int i = 0; i < 512; i++) mem[i] = sebs_pkg::MEM_RESET;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    chk_ack(busy, 1'b0);
    chk_ack(sda_oe, 1'b0);
    rd(9'h1fe, 4, 1'b1);
    for (int t = 0; t < 8; t++) begin
      pins <= 3'($urandom);
      wi <= ($urandom % 4) == 0;
      @(posedge clk);
      for (int j = 1; j < 8; j++) begin
        u_sebs_master.start();
        put(sel(1'b0, 1'b0) ^ 8'(1 << j), j == 1);
        u_sebs_master.stop();
      end
      wr(9'($urandom), t == 0 ? 20 : $urandom % 21);
      if (busy === 1'b1) poll();
      // Poll limit already counted as a mismatch
      if (timed_out) break;
      if (!inh) rd(9'h0, 1 + $urandom % 3, 1'b0);
      wi <= 1'($urandom);
      @(posedge clk);
      rd(9'($urandom), 1 + $urandom % 20, 1'b1);
    end
    test_done();
  end
endmodule
